/* bawd_map.svh */
`ifndef BAWD_MAP_SVH
`define BAWD_MAP_SVH
// register offsets (byte addresses in configuration space)
`define BAWD_OFF_STAT_IO 8'h1c
`define BAWD_OFF_MEM 8'h20
`define BAWD_OFF_PF_LOW 8'h24
`define BAWD_OFF_PF_BASE_UP 8'h28
`define BAWD_OFF_PF_LIM_UP 8'h2c
`define BAWD_OFF_IO_UP 8'h30
`define BAWD_OFF_CAP 8'h34
`define BAWD_OFF_BCTL 8'h3c
// reset values
`define BAWD_RST_IO_LOW 4'h0
`define BAWD_RST_MEM 32'h0000fff0
`define BAWD_RST_PF_LOW 32'h0001fff1
`define BAWD_RST_PF_UP 32'h00000000
`define BAWD_RST_IO_UP 32'h0000ffff
`define BAWD_RST_EXT 16'h0000
`define BAWD_CAP_OFFSET 32'h000000a0
// field positions
`define BAWD_BIT_PARITY_SEEN 31
`define BAWD_BIT_SYS_FAULT 30
`define BAWD_BIT_GOT_MA 29
`define BAWD_BIT_GOT_TA 28
`define BAWD_BIT_SENT_TA 27
`define BAWD_BIT_INIT_PARITY 24
`define BAWD_DEVSEL_MEDIUM 2'h1
`define BAWD_BIT_DISPLAY 19
`define BAWD_BIT_EXPANSION 18
`define BAWD_BIT_PARITY_ON 16
// writable mask of the bridge control bits kept here
`define BAWD_BCTL_MASK 32'h000d0000
// legacy display ranges
`define BAWD_VGA_MEM_LO 40'h00000a0000
`define BAWD_VGA_MEM_HI 40'h00000bffff
`define BAWD_VGA_IO1_LO 10'h3b0
`define BAWD_VGA_IO1_HI 10'h3bb
`define BAWD_VGA_IO2_LO 10'h3c0
`define BAWD_VGA_IO2_HI 10'h3df
`endif

/* bawd_pkg.sv */
package bawd_pkg;
	// decoded request as seen by the window logic
	typedef struct packed {
		logic valid;
		logic is_io;
		logic [63:0] addr;
	} bawd_req_t;
	// routing verdict
	typedef enum logic [1:0] {
		BAWD_NONE,
		BAWD_TO_SECONDARY,
		BAWD_PASS_OR_ABORT,
		BAWD_CLAIM_UP
	} bawd_route_t;
	// secondary bus event strobes
	typedef struct packed {
		logic addr_parity_tgt;
		logic data_parity_up;
		logic got_master_abort;
		logic got_target_abort;
		logic sent_target_abort;
		logic read_parity_bad;
		logic write_parity_fault_line_n_seen;
	} bawd_evt_t;
	// configuration access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] offset;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} bawd_cfg_t;
endpackage

/* bawd_decode.sv */
`timescale 1ns/100ps
`include "bawd_map.svh"
module bawd_decode
	import bawd_pkg::*;
(
	// clock and resets
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic power_good,
	// configuration access
	input wire bawd_cfg_t cfg,
	output logic [31:0] cfg_rdata,
	// non-prefetch extension byte pair {limit, base}
	input wire logic [15:0] np_ext_bytes,
	input wire logic chain_end,
	// host link request and verdict
	input wire bawd_req_t host_req,
	output bawd_route_t host_route,
	// secondary bus request and verdict
	input wire bawd_req_t sec_req,
	output bawd_route_t sec_route,
	output logic [1:0] sec_devsel_timing,
	// secondary bus events and error pins
	input wire bawd_evt_t evt,
	input wire logic sys_fault_line_n,
	input wire logic hotplug_fault_source
);
	// registers
	logic [3:0] io_upper_bound_reg, io_upper_bound_next;
	logic [3:0] io_lower_bound_reg, io_lower_bound_next;
	logic [31:0] mem_reg, mem_next;
	logic [31:0] pf_low_reg, pf_low_next;
	logic [31:0] pf_base_up_reg, pf_base_up_next;
	logic [31:0] pf_lim_up_reg, pf_lim_up_next;
	logic [31:0] io_up_reg, io_up_next;
	logic [31:0] bctl_reg, bctl_next;
	logic [31:0] rdata_reg, rdata_next;
	bawd_route_t host_route_reg, host_route_next;
	bawd_route_t sec_route_reg, sec_route_next;
	// status bits; all but the two parity bits are sticky on the power-good domain
	logic parity_fault_seen_reg, parity_fault_seen_next;
	logic sys_fault_received_reg, sys_fault_received_next;
	logic got_master_abort_reg, got_master_abort_next;
	logic got_target_abort_reg, got_target_abort_next;
	logic sent_target_abort_reg, sent_target_abort_next;
	logic initiator_parity_fault_reg, initiator_parity_fault_next;
	// pin synchronisers
	logic [1:0] sys_fault_line_n_sync_reg, hp_sync_reg, pwr_sync_reg;
	logic [1:0] sys_fault_line_n_sync_next, hp_sync_next, pwr_sync_next;
	logic sys_src;
	logic power_reset;
	logic parity_response_on, legacy_display_decode_on, legacy_expansion_decode_on;
	logic back_to_back_capable;

	// byte-enable merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				res[i*8 +: 8] = wd[i*8 +: 8];
		end
		return res & mask;
	endfunction

	// write-one-to-clear strobe for one status bit
	function automatic logic w1c(input bawd_cfg_t c, input int bitpos);
		return c.wr && c.offset == `BAWD_OFF_STAT_IO && c.byte_en[bitpos/8] && c.wdata[bitpos];
	endfunction

	// inclusive range check
	function automatic logic in_rng(input logic [39:0] a, input logic [39:0] lo,
		input logic [39:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// next values of the pin synchronisers; each stage moves one step per clock
	always_comb begin
		sys_fault_line_n_sync_next = {sys_fault_line_n_sync_reg[0], ~sys_fault_line_n};
		hp_sync_next = {hp_sync_reg[0], hotplug_fault_source};
		pwr_sync_next = {pwr_sync_reg[0], power_good};
	end

	// pins from outside pass two flip-flops; power_good reset is synchronised too
	always_ff @(posedge ref_clk) begin
		sys_fault_line_n_sync_reg <= sys_fault_line_n_sync_next;
		hp_sync_reg <= hp_sync_next;
		pwr_sync_reg <= pwr_sync_next;
	end
	// either source holds the system fault bit up
	assign sys_src = sys_fault_line_n_sync_reg[1] | hp_sync_reg[1];
	// power reset is active while the synchronised level is low
	assign power_reset = ~pwr_sync_reg[1];

	// control fields
	// enables held in bridge control
	assign parity_response_on = bctl_reg[`BAWD_BIT_PARITY_ON];
	assign legacy_display_decode_on = bctl_reg[`BAWD_BIT_DISPLAY];
	assign legacy_expansion_decode_on = bctl_reg[`BAWD_BIT_EXPANSION];
	assign back_to_back_capable = 1'b0;

	// window bounds
	logic [39:0] io_lo, io_hi, np_lo, np_hi, pf_lo, pf_hi;
	// a base above its limit leaves lo above hi, so nothing hits
	always_comb begin
		io_hi = {8'h00, 7'h00, io_up_reg[24:16], io_upper_bound_reg, 12'hfff};
		io_lo = {8'h00, 7'h00, io_up_reg[8:0], io_lower_bound_reg, 12'h000};
		np_hi = {np_ext_bytes[15:8], mem_reg[31:20], 20'hfffff};
		np_lo = {np_ext_bytes[7:0], mem_reg[15:4], 20'h00000};
		pf_hi = {pf_lim_up_reg[7:0], pf_low_reg[31:20], 20'hfffff};
		pf_lo = {pf_base_up_reg[7:0], pf_low_reg[15:4], 20'h00000};
	end

	// window hit for one request
	function automatic logic hit(input bawd_req_t r, input logic host,
		input logic [39:0] iol, input logic [39:0] ioh, input logic [39:0] npl,
		input logic [39:0] nph, input logic [39:0] pfl, input logic [39:0] pfh,
		input logic vga, input logic isa);
		logic [39:0] a;
		logic io_in, mem_in;
		a = r.addr[39:0];
		// secondary io keeps all 32 bits; its top seven were vetted by the caller
		// host io is 25 bits, zero-extended
		if (host && r.is_io)
			a = {15'h0000, r.addr[24:0]};
		// empty windows never hit, since lo > hi fails range check
		io_in = in_rng(a, iol, ioh);
		// the expansion limit only trims, never widens, the io window
		// first 256 bytes of each 1K within 64K
		if (isa && a[31:16] == 16'h0000 && a[9:8] != 2'b00)
			io_in = 1'b0;
		mem_in = in_rng(a, npl, nph) || in_rng(a, pfl, pfh);
		// legacy display ranges, host side only
		if (vga && host) begin
			mem_in = mem_in || in_rng(a, `BAWD_VGA_MEM_LO, `BAWD_VGA_MEM_HI);
			if (a[31:16] == 16'h0000 && ((a[9:0] >= `BAWD_VGA_IO1_LO &&
				a[9:0] <= `BAWD_VGA_IO1_HI) || (a[9:0] >= `BAWD_VGA_IO2_LO &&
				a[9:0] <= `BAWD_VGA_IO2_HI)))
				io_in = 1'b1;
		end
		// the space of the request picks which window verdict counts
		return r.is_io ? io_in : mem_in;
	endfunction

	// routing verdicts, registered
	// a verdict stands one cycle; an idle cycle returns to none
	always_comb begin
		host_route_next = BAWD_NONE;
		sec_route_next = BAWD_NONE;
		if (host_req.valid) begin
			if (hit(host_req, 1'b1, io_lo, io_hi, np_lo, np_hi, pf_lo, pf_hi,
				legacy_display_decode_on, legacy_expansion_decode_on))
				host_route_next = BAWD_TO_SECONDARY;
			else
				host_route_next = BAWD_PASS_OR_ABORT;
		end
		// secondary side: range checks come before the window test
		if (sec_req.valid) begin
			if (sec_req.is_io && sec_req.addr[31:25] != 7'h00)
				sec_route_next = BAWD_NONE;
			else if (!sec_req.is_io && sec_req.addr[63:40] != 24'h000000)
				sec_route_next = BAWD_NONE;
			else if (hit(sec_req, 1'b0, io_lo, io_hi, np_lo, np_hi, pf_lo, pf_hi,
				legacy_display_decode_on, legacy_expansion_decode_on))
				sec_route_next = BAWD_NONE;
			else
				sec_route_next = BAWD_CLAIM_UP;
		end
	end
	// verdicts leave from flip-flops
	assign host_route = host_route_reg;
	assign sec_route = sec_route_reg;
	assign sec_devsel_timing = `BAWD_DEVSEL_MEDIUM;

	// window and control register writes
	always_comb begin
		io_upper_bound_next = io_upper_bound_reg;
		io_lower_bound_next = io_lower_bound_reg;
		mem_next = mem_reg;
		pf_low_next = pf_low_reg;
		pf_base_up_next = pf_base_up_reg;
		pf_lim_up_next = pf_lim_up_reg;
		io_up_next = io_up_reg;
		bctl_next = bctl_reg;
		if (cfg.wr) begin
			if (cfg.offset == `BAWD_OFF_STAT_IO) begin
				if (cfg.byte_en[1])
					io_upper_bound_next = cfg.wdata[15:12];
				if (cfg.byte_en[0])
					io_lower_bound_next = cfg.wdata[7:4];
			end
			else if (cfg.offset == `BAWD_OFF_MEM)
				mem_next = merge(mem_reg, cfg.wdata, cfg.byte_en, 32'hfff0fff0);
			else if (cfg.offset == `BAWD_OFF_PF_LOW)
				pf_low_next = merge(pf_low_reg, cfg.wdata, cfg.byte_en, 32'hfff0fff0)
					| (`BAWD_RST_PF_LOW & 32'h000f000f);
			else if (cfg.offset == `BAWD_OFF_PF_BASE_UP)
				pf_base_up_next = merge(pf_base_up_reg, cfg.wdata, cfg.byte_en, 32'hffffffff);
			else if (cfg.offset == `BAWD_OFF_PF_LIM_UP)
				pf_lim_up_next = merge(pf_lim_up_reg, cfg.wdata, cfg.byte_en, 32'hffffffff);
			else if (cfg.offset == `BAWD_OFF_IO_UP)
				io_up_next = merge(io_up_reg, cfg.wdata, cfg.byte_en, 32'hffffffff);
			// only the decode and parity enables are writable here
			else if (cfg.offset == `BAWD_OFF_BCTL)
				bctl_next = merge(bctl_reg, cfg.wdata, cfg.byte_en, `BAWD_BCTL_MASK);
			// writes to any other offset are ignored
		end
	end

	// status bits: set wins over clear
	// an event in the cycle of its clear wins, so no event is lost
	always_comb begin
		parity_fault_seen_next = (parity_fault_seen_reg & ~w1c(cfg, `BAWD_BIT_PARITY_SEEN))
			| evt.addr_parity_tgt | evt.data_parity_up;
		// holds while sources asserted
		// the two-flop sync gives the sources two cycles of latency
		sys_fault_received_next = (sys_fault_received_reg & ~w1c(cfg, `BAWD_BIT_SYS_FAULT))
			| sys_src;
		got_master_abort_next = (got_master_abort_reg & ~w1c(cfg, `BAWD_BIT_GOT_MA))
			| evt.got_master_abort;
		got_target_abort_next = (got_target_abort_reg & ~w1c(cfg, `BAWD_BIT_GOT_TA))
			| evt.got_target_abort;
		sent_target_abort_next = (sent_target_abort_reg & ~w1c(cfg, `BAWD_BIT_SENT_TA))
			| evt.sent_target_abort;
		initiator_parity_fault_next = (initiator_parity_fault_reg
			& ~w1c(cfg, `BAWD_BIT_INIT_PARITY))
			| (parity_response_on & (evt.read_parity_bad | evt.write_parity_fault_line_n_seen));
	end

	// read mux
	always_comb begin
		rdata_next = 32'h00000000;
		if (cfg.rd) begin
			if (cfg.offset == `BAWD_OFF_STAT_IO)
				rdata_next = {parity_fault_seen_reg, sys_fault_received_reg,
					got_master_abort_reg, got_target_abort_reg, sent_target_abort_reg,
					`BAWD_DEVSEL_MEDIUM, initiator_parity_fault_reg, back_to_back_capable,
					7'h00, io_upper_bound_reg, 4'h0, io_lower_bound_reg, 4'h0};
			else if (cfg.offset == `BAWD_OFF_MEM)
				rdata_next = mem_reg;
			else if (cfg.offset == `BAWD_OFF_PF_LOW)
				rdata_next = pf_low_reg;
			else if (cfg.offset == `BAWD_OFF_PF_BASE_UP)
				rdata_next = pf_base_up_reg;
			else if (cfg.offset == `BAWD_OFF_PF_LIM_UP)
				rdata_next = pf_lim_up_reg;
			else if (cfg.offset == `BAWD_OFF_IO_UP)
				rdata_next = io_up_reg;
			else if (cfg.offset == `BAWD_OFF_CAP)
				rdata_next = `BAWD_CAP_OFFSET;
			// bridge control enables read back as written
			else if (cfg.offset == `BAWD_OFF_BCTL)
				rdata_next = bctl_reg;
			// unmapped offsets fall through to zero
		end
	end
	assign cfg_rdata = rdata_reg;

	// chip-reset registers
	// either reset returns windows to defaults and the outputs to idle
	always_ff @(posedge ref_clk) begin
		if (reset || power_reset) begin
			io_upper_bound_reg <= `BAWD_RST_IO_LOW;
			io_lower_bound_reg <= `BAWD_RST_IO_LOW;
			mem_reg <= `BAWD_RST_MEM;
			pf_low_reg <= `BAWD_RST_PF_LOW;
			pf_base_up_reg <= `BAWD_RST_PF_UP;
			pf_lim_up_reg <= `BAWD_RST_PF_UP;
			io_up_reg <= `BAWD_RST_IO_UP;
			// control, read data and verdicts back to idle
			bctl_reg <= 32'h00000000;
			rdata_reg <= 32'h00000000;
			host_route_reg <= BAWD_NONE;
			sec_route_reg <= BAWD_NONE;
		end else begin
			// registered next values
			io_upper_bound_reg <= io_upper_bound_next;
			io_lower_bound_reg <= io_lower_bound_next;
			mem_reg <= mem_next;
			pf_low_reg <= pf_low_next;
			pf_base_up_reg <= pf_base_up_next;
			pf_lim_up_reg <= pf_lim_up_next;
			io_up_reg <= io_up_next;
			bctl_reg <= bctl_next;
			rdata_reg <= rdata_next;
			host_route_reg <= host_route_next;
			sec_route_reg <= sec_route_next;
		end
	end

	// chip-reset status bits
	// parity bits are not sticky and follow the chip reset
	always_ff @(posedge ref_clk) begin
		if (reset || power_reset)
			parity_fault_seen_reg <= 1'b0;
		else
			parity_fault_seen_reg <= parity_fault_seen_next;
		if (reset || power_reset)
			initiator_parity_fault_reg <= 1'b0;
		else
			initiator_parity_fault_reg <= initiator_parity_fault_next;
	end

	// sticky bits survive chip reset
	// only the loss of power good or a write-one-to-clear clears them
	always_ff @(posedge ref_clk) begin
		if (power_reset) begin
			// power-good loss clears the record
			sys_fault_received_reg <= 1'b0;
			got_master_abort_reg <= 1'b0;
			got_target_abort_reg <= 1'b0;
			sent_target_abort_reg <= 1'b0;
		end else begin
			sys_fault_received_reg <= sys_fault_received_next;
			got_master_abort_reg <= got_master_abort_next;
			got_target_abort_reg <= got_target_abort_next;
			sent_target_abort_reg <= sent_target_abort_next;
		end
	end
endmodule // bawd_decode

/* bawd_decode_asserts.sv */
`timescale 1ns/100ps
module bawd_decode_asserts
	import bawd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// configuration side
	input wire bawd_cfg_t cfg,
	input wire logic [31:0] cfg_rdata,
	// routing side
	input wire bawd_req_t host_req,
	input wire bawd_route_t host_route,
	input wire bawd_req_t sec_req,
	input wire bawd_route_t sec_route,
	input wire logic [1:0] sec_devsel_timing
);
	// all checks share the core clock
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// decode speed is fixed
	a_devsel_medium: assert property (sec_devsel_timing == 2'h1)
		else $error("devsel timing not medium");
	// host verdicts one cycle after the request
	a_host_verdict: assert property (host_req.valid |=>
		host_route inside {BAWD_TO_SECONDARY, BAWD_PASS_OR_ABORT})
		else $error("host verdict wrong kind");
	a_host_idle: assert property (!host_req.valid |=> host_route == BAWD_NONE)
		else $error("host verdict without request");
	a_sec_verdict: assert property (sec_req.valid |=> sec_route inside {BAWD_NONE, BAWD_CLAIM_UP})
		else $error("secondary verdict wrong kind");
	// out of range secondary addresses are ignored
	a_sec_io_high: assert property (sec_req.valid && sec_req.is_io &&
		|sec_req.addr[31:25] |=> sec_route == BAWD_NONE)
		else $error("high io address claimed");
	a_sec_mem_high: assert property (sec_req.valid && !sec_req.is_io &&
		|sec_req.addr[63:40] |=> sec_route == BAWD_NONE)
		else $error("high memory address claimed");
	// read data stands one cycle only
	a_rdata_idle: assert property (!cfg.rd |=> cfg_rdata == 32'h0)
		else $error("read data without read");
	a_cap_pointer: assert property (cfg.rd && cfg.offset == 8'h34 |=> cfg_rdata == 32'ha0)
		else $error("capability offset wrong");
	a_status_fixed: assert property (cfg.rd && cfg.offset == 8'h1c |=>
		{cfg_rdata[26:25], cfg_rdata[23], cfg_rdata[11:8], cfg_rdata[3:0]} == 11'h200)
		else $error("fixed status bits wrong");
	a_unmapped_zero: assert property (cfg.rd && cfg.offset == 8'h38 |=> cfg_rdata == 32'h0)
		else $error("unmapped read not zero");
	// main scenarios reached
	c_host_down: cover property (host_route == BAWD_TO_SECONDARY);
	c_sec_up: cover property (sec_route == BAWD_CLAIM_UP);
	c_cap_read: cover property (cfg.rd && cfg.offset == 8'h34);
endmodule // bawd_decode_asserts

bind bawd_decode bawd_decode_asserts u_chk (.ref_clk(ref_clk), .reset(reset), .cfg(cfg),
	.cfg_rdata(cfg_rdata), .host_req(host_req), .host_route(host_route), .sec_req(sec_req),
	.sec_route(sec_route), .sec_devsel_timing(sec_devsel_timing));

/* bawd_agent.sv */
`timescale 1ns/100ps
module bawd_agent
	import bawd_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// requests from host link and secondary masters
	output bawd_req_t host_req,
	output bawd_req_t sec_req,
	// event strobes and error pins
	output bawd_evt_t evt,
	output logic sys_fault_line_n,
	output logic hotplug_fault_source
);
	// idle state at time zero
	initial begin
		host_req = '0;
		sec_req = '0;
		evt = '0;
		sys_fault_line_n = 1'h1;
		hotplug_fault_source = 1'h0;
	end
	// one-cycle request; an idle side shows a changing address
	task send(input logic host, input logic io, input logic [63:0] a);
		bawd_req_t r;
		bawd_req_t z;
		r = '{valid: 1'h1, is_io: io, addr: a};
		z = '{valid: 1'h0, is_io: ~io, addr: ~a};
		@(posedge ref_clk);
		#1;
		host_req = host ? r : z;
		sec_req = host ? z : r;
		@(posedge ref_clk);
		#1;
		host_req = z;
		sec_req = z;
	endtask
	// one-cycle event strobe
	task pulse(input bawd_evt_t e);
		@(posedge ref_clk);
		#1;
		evt = e;
		@(posedge ref_clk);
		#1;
		evt = '0;
	endtask
	// error pin levels
	task pins(input logic line_n, input logic hp);
		@(posedge ref_clk);
		#1;
		sys_fault_line_n = line_n;
		hotplug_fault_source = hp;
	endtask
endmodule // bawd_agent

/* testbench.sv */
`timescale 1ns/100ps
module testbench
	import bawd_pkg::*;
;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic power_good = 1'h0;
	bawd_cfg_t cfg = '0;
	logic [15:0] np_ext_bytes = 16'h0201;
	logic chain_end = 1'h0;
	logic [31:0] cfg_rdata;
	bawd_req_t host_req;
	bawd_req_t sec_req;
	bawd_route_t host_route;
	bawd_route_t sec_route;
	logic [1:0] sec_devsel_timing;
	bawd_evt_t evt;
	logic sys_fault_line_n;
	logic hotplug_fault_source;
	int miscompares = 0;
	int checked = 0;
	logic [31:0] rd;
	// 200 MHz core clock
	always #2.5 ref_clk = ~ref_clk;
	// far-side agents
	bawd_agent agent (.ref_clk(ref_clk), .host_req(host_req), .sec_req(sec_req), .evt(evt),
		.sys_fault_line_n(sys_fault_line_n), .hotplug_fault_source(hotplug_fault_source));
	bawd_decode dut (.ref_clk(ref_clk), .reset(reset), .power_good(power_good), .cfg(cfg),
		.cfg_rdata(cfg_rdata), .np_ext_bytes(np_ext_bytes), .chain_end(chain_end),
		.host_req(host_req), .host_route(host_route), .sec_req(sec_req), .sec_route(sec_route),
		.sec_devsel_timing(sec_devsel_timing), .evt(evt), .sys_fault_line_n(sys_fault_line_n),
		.hotplug_fault_source(hotplug_fault_source));
	// comparisons
	task cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task cmp_route(input string n, input bawd_route_t e, input bawd_route_t g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// configuration cycles
	task cfg_wr(input logic [7:0] off, input logic [31:0] d);
		@(posedge ref_clk);
		#1;
		cfg = '{wr: 1'h1, rd: 1'h0, offset: off, byte_en: 4'hf, wdata: d};
		@(posedge ref_clk);
		#1;
		cfg = '0;
	endtask
	task rdchk(input logic [7:0] off, input logic [31:0] m, input logic [31:0] e);
		@(posedge ref_clk);
		#1;
		cfg = '{wr: 1'h0, rd: 1'h1, offset: off, byte_en: 4'hf, wdata: 32'h0};
		@(posedge ref_clk);
		#1;
		cfg = '0;
		rd = cfg_rdata;
		cmp32("cfg_rdata", e, rd & m);
	endtask
	task route(input logic host, input logic io, input logic [63:0] a, input bawd_route_t e);
		agent.send(host, io, a);
		cmp_route(host ? "host_route" : "sec_route", e, host ? host_route : sec_route);
	endtask
	task chip_reset;
		@(posedge ref_clk);
		#1;
		reset = 1'h1;
		@(posedge ref_clk);
		#1;
		reset = 1'h0;
	endtask
	// reset values and requests that miss the reset windows
	task t_defaults;
		rdchk(8'h20, 32'hffffffff, 32'h0000fff0);
		rdchk(8'h24, 32'hffffffff, 32'h0001fff1);
		rdchk(8'h28, 32'hffffffff, 32'h0);
		rdchk(8'h2c, 32'hffffffff, 32'h0);
		rdchk(8'h30, 32'hffffffff, 32'h0000ffff);
		rdchk(8'h34, 32'hffffffff, 32'h000000a0);
		rdchk(8'h38, 32'hffffffff, 32'h0);
		rdchk(8'h1c, 32'hff80ffff, 32'h02000000);
		cmp32("sec_devsel_timing", 32'h1, {30'h0, sec_devsel_timing});
		route(1'h1, 1'h0, 64'h0010_0000, BAWD_PASS_OR_ABORT);
		route(1'h0, 1'h0, 64'h0010_0000, BAWD_CLAIM_UP);
		route(1'h1, 1'h1, 64'h1000, BAWD_PASS_OR_ABORT);
		route(1'h0, 1'h1, 64'h1000, BAWD_CLAIM_UP);
	endtask
	// io window edges and address widths
	task t_io;
		cfg_wr(8'h30, 32'h00010001);
		cfg_wr(8'h1c, 32'h00003f1f);
		rdchk(8'h1c, 32'h0000ffff, 32'h00003010);
		route(1'h1, 1'h1, 64'h4001_1000, BAWD_TO_SECONDARY);
		route(1'h1, 1'h1, 64'h0001_3fff, BAWD_TO_SECONDARY);
		route(1'h1, 1'h1, 64'h0001_4000, BAWD_PASS_OR_ABORT);
		route(1'h0, 1'h1, 64'h0001_1000, BAWD_NONE);
		route(1'h0, 1'h1, 64'h0001_0fff, BAWD_CLAIM_UP);
		route(1'h0, 1'h1, 64'h0201_1000, BAWD_NONE);
		cfg_wr(8'h3c, 32'h00040000);
		route(1'h1, 1'h1, 64'h0001_1100, BAWD_TO_SECONDARY);
		cfg_wr(8'h30, 32'h0);
		route(1'h1, 1'h1, 64'h1100, BAWD_PASS_OR_ABORT);
		route(1'h1, 1'h1, 64'h1000, BAWD_TO_SECONDARY);
	endtask
	// memory windows and legacy display range
	task t_mem;
		cfg_wr(8'h20, 32'h00500010);
		route(1'h1, 1'h0, 64'h01_0010_0000, BAWD_TO_SECONDARY);
		route(1'h1, 1'h0, 64'h02_005f_ffff, BAWD_TO_SECONDARY);
		route(1'h1, 1'h0, 64'h01_000f_ffff, BAWD_PASS_OR_ABORT);
		route(1'h0, 1'h0, 64'h02_0060_0000, BAWD_CLAIM_UP);
		route(1'h0, 1'h0, 64'h0102_0060_0000, BAWD_NONE);
		cfg_wr(8'h28, 32'h5);
		cfg_wr(8'h2c, 32'h5);
		cfg_wr(8'h24, 32'h00200010);
		rdchk(8'h24, 32'hffffffff, 32'h00210011);
		rdchk(8'h2c, 32'hffffffff, 32'h5);
		route(1'h1, 1'h0, 64'h05_0020_0000, BAWD_TO_SECONDARY);
		route(1'h0, 1'h0, 64'h05_0030_0000, BAWD_CLAIM_UP);
		cfg_wr(8'h3c, 32'h00080000);
		route(1'h1, 1'h0, 64'h000a_0000, BAWD_TO_SECONDARY);
		route(1'h1, 1'h1, 64'h03b0, BAWD_TO_SECONDARY);
		route(1'h0, 1'h1, 64'h03b0, BAWD_CLAIM_UP);
	endtask
	// status bits, sticky bits and error sources
	task t_status;
		agent.pulse(bawd_evt_t'(7'h5c));
		rdchk(8'h1c, 32'hb8000000, 32'hb8000000);
		chip_reset;
		rdchk(8'h1c, 32'hb8000000, 32'h38000000);
		cfg_wr(8'h1c, 32'h38000000);
		rdchk(8'h1c, 32'h38000000, 32'h0);
		agent.pulse(bawd_evt_t'(7'h02));
		rdchk(8'h1c, 32'h01000000, 32'h0);
		cfg_wr(8'h3c, 32'h00010000);
		agent.pulse(bawd_evt_t'(7'h01));
		rdchk(8'h1c, 32'h01000000, 32'h01000000);
		agent.pins(1'h0, 1'h0);
		repeat (4) @(posedge ref_clk);
		cfg_wr(8'h1c, 32'h40000000);
		rdchk(8'h1c, 32'h40000000, 32'h40000000);
		agent.pins(1'h1, 1'h0);
		repeat (4) @(posedge ref_clk);
		cfg_wr(8'h1c, 32'h40000000);
		rdchk(8'h1c, 32'h40000000, 32'h0);
		agent.pins(1'h1, 1'h1);
		repeat (4) @(posedge ref_clk);
		agent.pins(1'h1, 1'h0);
		chip_reset;
		rdchk(8'h1c, 32'h40000000, 32'h40000000);
		agent.pulse(bawd_evt_t'(7'h10));
		@(posedge ref_clk);
		#1;
		power_good = 1'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		power_good = 1'h1;
		repeat (3) @(posedge ref_clk);
		rdchk(8'h1c, 32'h60000000, 32'h0);
	endtask
	// verdict and end of run
	task give_verdict;
		if (miscompares == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		#1;
		power_good = 1'h1;
		repeat (2) @(posedge ref_clk);
		#1;
		reset = 1'h0;
		repeat (2) @(posedge ref_clk);
		t_defaults;
		t_io;
		t_mem;
		t_status;
		give_verdict;
	end
	// hang guard
	initial begin
		#50000;
		miscompares++;
		give_verdict;
	end
endmodule // testbench
